// File: regbank_pkg.sv
// package: special register map, field positions, reset values and carriers
package regbank_pkg;

   // ----------------------------------------------------------------
   // register offsets (word index, taken from PADDR[9:2] of the APB address)
   // ----------------------------------------------------------------
   localparam logic [7:0] DPTR_LO_ADDR  = 8'h82;
   localparam logic [7:0] DPTR_HI_ADDR  = 8'h83;
   localparam logic [7:0] CONV0_CTL     = 8'h8E;
   localparam logic [7:0] CLK_DIV_ADDR  = 8'h95;
   localparam logic [7:0] CONV1_CTL     = 8'h97;
   localparam logic [7:0] MODE_B_ADDR   = 8'hA1;
   localparam logic [7:0] AUX_ADDR      = 8'hA2;
   localparam logic [7:0] INSEL_ADDR    = 8'hA3;
   localparam logic [7:0] COMPARATOR1_CONTROL_ADDR     = 8'hAC;
   localparam logic [7:0] COMPARATOR2_CONTROL_ADDR     = 8'hAD;
   localparam logic [7:0] BND_LO_ADDR   = 8'hBC;
   localparam logic [7:0] BAUD_CTL_ADDR = 8'hBD;
   localparam logic [7:0] BAUD_LO_ADDR  = 8'hBE;
   localparam logic [7:0] BAUD_HI_ADDR  = 8'hBF;
   localparam logic [7:0] MODE_A_ADDR   = 8'hC0;
   localparam logic [7:0] BND_HI_ADDR   = 8'hC4;
   localparam logic [7:0] RES0_ADDR     = 8'hD5;
   localparam logic [7:0] RES1_ADDR     = 8'hD6;
   localparam logic [7:0] RES2_ADDR     = 8'hD7;
   localparam logic [7:0] ACC_ADDR      = 8'hE0;
   localparam logic [7:0] FLASH_HI_ADDR = 8'hE7;
   localparam logic [7:0] BREG_ADDR     = 8'hF0;
   localparam logic [7:0] C0RES3_ADDR   = 8'hF4;
   localparam logic [7:0] C1RES3_ADDR   = 8'hF5;
   // bit-access window: address of bit 0 of each bit-addressable register
   localparam logic [7:0] ACC_BIT_BASE  = 8'hE0;
   localparam logic [7:0] BREG_BIT_BASE = 8'hF0;

   // ----------------------------------------------------------------
   // field layout: writable masks, fixed-one bits, reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CONV0_MASK    = 8'h04;  // enable at bit 2 only
   localparam logic [7:0] MODE_B_MASK   = 8'hEE;
   localparam logic [7:0] AUX_MASK      = 8'hF9;  // bit 2 fixed zero
   localparam logic [7:0] INSEL_MASK    = 8'hF0;
   localparam logic [7:0] CMP_MASK      = 8'h3F;
   localparam logic [7:0] BAUD_CTL_MASK = 8'h03;
   localparam logic [7:0] MODE_A_MASK   = 8'hF0;
   localparam logic [7:0] FULL_MASK     = 8'hFF;
   localparam logic [7:0] FIXED_ONES    = 8'h00;  // no fixed-one bits here
   localparam logic [7:0] RESET_ZERO    = 8'h00;
   localparam logic [7:0] BND_HI_RESET  = 8'hFF;
   localparam int         AUX_SOFTWARE_RESET_BIT  = 3;
   localparam int         NUM_REGS      = 24;

   // ----------------------------------------------------------------
   // register indices into the storage array
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      R_DPL, R_DPH, R_C0CTL, R_DIV, R_C1CTL, R_MODB, R_AUX, R_INS,
      R_COMPARATOR1_CONTROL, R_COMPARATOR2_CONTROL, R_BNDL, R_BAUDC, R_BAUDL, R_BAUDH, R_MODA,
      R_BNDH, R_RES0, R_RES1, R_RES2, R_ACC, R_FLH, R_B, R_C0R3,
      R_C1R3, R_NONE
   } reg_idx_t;

   // decoded control outputs toward the peripherals
   typedef struct packed {
      logic       converter0_enable;
      logic       converter1_enable;
      logic       boundary_irq_enable;
      logic       conversion_irq_enable;
      logic       timer_trigger_mode;
      logic       edge_trigger_mode;
      logic       conversion_done_flag;
      logic [1:0] start_mode;
      logic       clock_low_power;
      logic       break_reset_enable;
      logic       timer1_toggle_enable;
      logic       timer0_toggle_enable;
      logic       software_reset;
      logic       pointer_select;
      logic       baud_source_select;
      logic       baud_generator_enable;
      logic [7:0] clock_divider;
      logic [5:0] comparator1;
      logic [5:0] comparator2;
   } ctrl_t;

endpackage

// File: regbank_decode.sv
// address decoder: maps an offset to a register index and its field masks
`timescale 1ns/1ps
module regbank_decode
(
   input  wire logic [7:0]          addr,
   output regbank_pkg::reg_idx_t    idx,
   output logic [7:0]               wmask,
   output logic [7:0]               rst_val
);
   import regbank_pkg::*;

   // ------------------------------------------------------------
   // offset decode
   // ------------------------------------------------------------
   // if/else chain so that a miss falls to R_NONE with a zero mask
   always_comb
   begin
      idx     = R_NONE;
      wmask   = 8'h00;
      rst_val = RESET_ZERO;
      if (addr == DPTR_LO_ADDR)
      begin
         idx = R_DPL;   wmask = FULL_MASK;
      end
      else if (addr == DPTR_HI_ADDR)
      begin
         idx = R_DPH;   wmask = FULL_MASK;
      end
      else if (addr == CONV0_CTL)
      begin
         idx = R_C0CTL; wmask = CONV0_MASK;
      end
      else if (addr == CLK_DIV_ADDR)
      begin
         idx = R_DIV;   wmask = FULL_MASK;
      end
      else if (addr == CONV1_CTL)
      begin
         idx = R_C1CTL; wmask = FULL_MASK;
      end
      else if (addr == MODE_B_ADDR)
      begin
         idx = R_MODB;  wmask = MODE_B_MASK;
      end
      else if (addr == AUX_ADDR)
      begin
         idx = R_AUX;   wmask = AUX_MASK;
      end
      else if (addr == INSEL_ADDR)
      begin
         idx = R_INS;   wmask = INSEL_MASK;
      end
      else if (addr == COMPARATOR1_CONTROL_ADDR)
      begin
         idx = R_COMPARATOR1_CONTROL;  wmask = CMP_MASK;
      end
      else if (addr == COMPARATOR2_CONTROL_ADDR)
      begin
         idx = R_COMPARATOR2_CONTROL;  wmask = CMP_MASK;
      end
      else if (addr == BND_LO_ADDR)
      begin
         idx = R_BNDL;  wmask = FULL_MASK;
      end
      else if (addr == BAUD_CTL_ADDR)
      begin
         idx = R_BAUDC; wmask = BAUD_CTL_MASK;
      end
      else if (addr == BAUD_LO_ADDR)
      begin
         idx = R_BAUDL; wmask = FULL_MASK;
      end
      else if (addr == BAUD_HI_ADDR)
      begin
         idx = R_BAUDH; wmask = FULL_MASK;
      end
      else if (addr == MODE_A_ADDR)
      begin
         idx = R_MODA;  wmask = MODE_A_MASK;
      end
      else if (addr == BND_HI_ADDR)
      begin
         idx = R_BNDH;  wmask = FULL_MASK;
         rst_val = BND_HI_RESET;
      end
      else if (addr == RES0_ADDR)
      begin
         idx = R_RES0;  wmask = FULL_MASK;
      end
      else if (addr == RES1_ADDR)
      begin
         idx = R_RES1;  wmask = FULL_MASK;
      end
      else if (addr == RES2_ADDR)
      begin
         idx = R_RES2;  wmask = FULL_MASK;
      end
      else if (addr == ACC_ADDR)
      begin
         idx = R_ACC;   wmask = FULL_MASK;
      end
      else if (addr == FLASH_HI_ADDR)
      begin
         idx = R_FLH;   wmask = FULL_MASK;
      end
      else if (addr == BREG_ADDR)
      begin
         idx = R_B;     wmask = FULL_MASK;
      end
      else if (addr == C0RES3_ADDR)
      begin
         idx = R_C0R3;  wmask = FULL_MASK;
      end
      else if (addr == C1RES3_ADDR)
      begin
         idx = R_C1R3;  wmask = FULL_MASK;
      end
   end

endmodule

// File: regbank.sv
// special register bank: APB slave with byte and bit access, control outputs
//
// Function
// - reserved bits written zero, read undefined
// - fixed-zero bits always read zero
// - fixed-one bits always read one
// - accumulator and B reachable bit by bit
// - upper boundary resets to all ones
// - baud control: select bit1, enable bit0
// - auxiliary register layout, bit2 fixed zero
// - converter1 control holds eight control bits
// - converter0 control: only enable at bit2
// - comparator controls use bits 5 to 0
// - clock divider is full 8-bit register
`timescale 1ns/1ps
module regbank
(
   input  wire logic                CLK,
   input  wire logic                RST_N,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [31:0]         PADDR,
   input  wire logic [31:0]         PWDATA,
   input  wire logic [3:0]          PSTRB,
   input  wire logic                BIT_MODE,
   input  wire logic                CONV_DONE_SET,
   input  wire logic                COMPARATOR1_CONTROL_CHANGE_SET,
   input  wire logic                COMPARATOR2_CONTROL_CHANGE_SET,
   input  wire logic                COMPARATOR1_CONTROL_OUT,
   input  wire logic                COMPARATOR2_CONTROL_OUT,
   output logic                     PREADY,
   output logic [31:0]              PRDATA,
   output logic                     PSLVERR,
   output regbank_pkg::ctrl_t       CTRL
);
   import regbank_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   // one packed struct holds every flop, registered in one place
   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] regs;
      logic                     ready;
      logic [31:0]              rdata;
      logic                     slverr;
      ctrl_t                    ctrl;
   } state_t;

   state_t     s_q;
   state_t     s_d;
   reg_idx_t   idx;
   logic [7:0] wmask;
   logic [7:0] rst_val;
   logic [7:0] byte_addr;

   // BIT_MODE selects the bit window: address is a bit address
   assign byte_addr = PADDR[9:2];

   regbank_decode u_decode
   (
      .addr    (byte_addr),
      .idx     (idx),
      .wmask   (wmask),
      .rst_val (rst_val)
   );

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // merge masked write data; fixed-one bits forced, others held
   function automatic logic [7:0] merge
   (
      input logic [7:0] old_v,
      input logic [7:0] new_v,
      input logic [7:0] mask
   );
      merge = (old_v & ~mask) | (new_v & mask) | FIXED_ONES;
   endfunction

   // bit window hit: returns register index of the target byte
   function automatic reg_idx_t bit_target
   (
      input logic [7:0] baddr
   );
      bit_target = R_NONE;
      if (baddr[7:3] == ACC_BIT_BASE[7:3])
         bit_target = R_ACC;
      else if (baddr[7:3] == BREG_BIT_BASE[7:3])
         bit_target = R_B;
   endfunction

   // decode register bytes into the peripheral control bundle
   function automatic ctrl_t unpack
   (
      input logic [NUM_REGS-1:0][7:0] r
   );
      unpack.converter0_enable     = r[R_C0CTL][2];
      unpack.boundary_irq_enable   = r[R_C1CTL][7];
      unpack.conversion_irq_enable = r[R_C1CTL][6];
      unpack.timer_trigger_mode    = r[R_C1CTL][5];
      unpack.edge_trigger_mode     = r[R_C1CTL][4];
      unpack.conversion_done_flag  = r[R_C1CTL][3];
      unpack.converter1_enable     = r[R_C1CTL][2];
      unpack.start_mode            = r[R_C1CTL][1:0];
      unpack.clock_low_power       = r[R_AUX][7];
      unpack.break_reset_enable    = r[R_AUX][6];
      unpack.timer1_toggle_enable  = r[R_AUX][5];
      unpack.timer0_toggle_enable  = r[R_AUX][4];
      unpack.software_reset        = r[R_AUX][AUX_SOFTWARE_RESET_BIT];
      unpack.pointer_select        = r[R_AUX][0];
      unpack.baud_source_select    = r[R_BAUDC][1];
      unpack.baud_generator_enable = r[R_BAUDC][0];
      unpack.clock_divider         = r[R_DIV];
      unpack.comparator1           = r[R_COMPARATOR1_CONTROL][5:0];
      unpack.comparator2           = r[R_COMPARATOR2_CONTROL][5:0];
   endfunction

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      reg_idx_t   tgt;
      logic       setup;
      logic [7:0] cur;
      logic [7:0] wb;
      logic [2:0] bpos;
      logic       access;
      tgt    = R_NONE;
      setup  = 1'b0;
      access = 1'b0;
      cur   = 8'h00;
      wb    = 8'h00;
      bpos  = 3'b000;
      s_d   = s_q;
      s_d.ready  = 1'b0;
      s_d.slverr = 1'b0;

      // software reset is a one-shot request: clears itself
      s_d.regs[R_AUX][AUX_SOFTWARE_RESET_BIT] = 1'b0;

      // hardware flags; a set in the same cycle beats a write clear
      if (CONV_DONE_SET)
         s_d.regs[R_C1CTL][3] = 1'b1;
      // comparator output state follows the analog outputs
      s_d.regs[R_COMPARATOR1_CONTROL][1] = COMPARATOR1_CONTROL_OUT;
      s_d.regs[R_COMPARATOR2_CONTROL][1] = COMPARATOR2_CONTROL_OUT;

      // no wait state: ready answers the setup phase, so read data is
      // loaded there; a write lands only at the access edge where ready
      // is seen, so its effect on CTRL shows at that same edge, together with the register
      setup  = PSEL && !PENABLE;
      access = PSEL && PENABLE && s_q.ready;
      tgt    = BIT_MODE ? bit_target(byte_addr) : idx;
      bpos   = byte_addr[2:0];
      if (setup)
      begin
         s_d.ready = 1'b1;
         if (tgt == R_NONE)
         begin
            // undefined location: error answer, no state change
            s_d.slverr = 1'b1;
            s_d.rdata  = 32'h0000_0000;
         end
         else if (!PWRITE)
         begin
            cur = s_q.regs[tgt];
            if (BIT_MODE)
               s_d.rdata = {31'h0000_0000, cur[bpos]};
            else
               s_d.rdata = {24'h00_0000, cur};
         end
      end

      // write commit at the completing access edge; misses change nothing
      if (access && PWRITE && tgt != R_NONE)
      begin
         cur = s_q.regs[tgt];
         if (!PSTRB[0])
            wb = cur;
         else if (BIT_MODE)
         begin
            wb       = cur;
            wb[bpos] = PWDATA[0];
         end
         else
            wb = merge(cur, PWDATA[7:0], wmask);
         // keep a same-cycle hardware set on writable flags
         if (tgt == R_C1CTL && CONV_DONE_SET)
            wb[3] = 1'b1;
         if (tgt == R_COMPARATOR1_CONTROL)
         begin
            wb[1] = COMPARATOR1_CONTROL_OUT;
            if (COMPARATOR1_CONTROL_CHANGE_SET)
               wb[0] = 1'b1;
         end
         if (tgt == R_COMPARATOR2_CONTROL)
         begin
            wb[1] = COMPARATOR2_CONTROL_OUT;
            if (COMPARATOR2_CONTROL_CHANGE_SET)
               wb[0] = 1'b1;
         end
         s_d.regs[tgt] = wb;
      end

      // change flags outside a write to their own register
      if (COMPARATOR1_CONTROL_CHANGE_SET)
         s_d.regs[R_COMPARATOR1_CONTROL][0] = 1'b1;
      if (COMPARATOR2_CONTROL_CHANGE_SET)
         s_d.regs[R_COMPARATOR2_CONTROL][0] = 1'b1;

      s_d.ctrl = unpack(s_d.regs);
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   // reset loads constants only; boundary high comes up all ones
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s_q <= '0;
         s_q.regs[R_BNDH] <= BND_HI_RESET;
      end
      else
         s_q <= s_d;
   end

   // ------------------------------------------------------------
   // outputs, all straight from flops
   // ------------------------------------------------------------
   assign PREADY  = s_q.ready;
   assign PRDATA  = s_q.rdata;
   assign PSLVERR = s_q.slverr;
   assign CTRL    = s_q.ctrl;

   // rst_val is unused; the only non-zero reset value is applied above from BND_HI_RESET
   logic unused_rst;
   assign unused_rst = ^rst_val;

endmodule

// File: regbank_sva.sv
// checker: bus timing and register layout properties of the bank
`timescale 1ns/1ps
module regbank_sva
(
   input wire logic               CLK,
   input wire logic               RST_N,
   input wire logic               PSEL,
   input wire logic               PENABLE,
   input wire logic               PWRITE,
   input wire logic [31:0]        PADDR,
   input wire logic [31:0]        PWDATA,
   input wire logic [3:0]         PSTRB,
   input wire logic               BIT_MODE,
   input wire logic               PREADY,
   input wire logic [31:0]        PRDATA,
   input wire regbank_pkg::ctrl_t CTRL
);
   import regbank_pkg::*;
   // ----------------
   // sequences
   // ----------------
   // register offset sits in the word index of the byte address
   wire [7:0] ofs = PADDR[9:2];
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_rd(a);
      PREADY && !PWRITE && !BIT_MODE && ofs == a;
   endsequence
   // a write completes at the access edge where ready is seen high
   sequence s_wr(a);
      s_setup ##1 PSEL && PENABLE && PREADY && PWRITE && PSTRB[0]
         && !BIT_MODE && ofs == a;
   endsequence
   // ----------------
   // properties
   // ----------------
   a_ready_next: assert property (s_setup |=> PREADY)
      else $error("no ready after setup");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
      else $error("ready outside access phase");
   a_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_aux_fixed: assert property (s_rd(AUX_ADDR) |-> !PRDATA[2])
      else $error("fixed zero bit read as one");
   a_conv0_only: assert property (
      s_rd(CONV0_CTL) |-> (PRDATA[7:0] & ~CONV0_MASK) == 8'h00)
      else $error("converter0 control extra bits");
   a_baud_top: assert property (
      s_rd(BAUD_CTL_ADDR) |-> PRDATA[7:2] == 6'h00)
      else $error("baud control upper bits set");
   a_cmp_top: assert property (
      s_rd(COMPARATOR1_CONTROL_ADDR) |-> PRDATA[7:6] == 2'h0)
      else $error("comparator top bits set");
   a_conv0_ctrl: assert property (
      s_wr(CONV0_CTL) |=> CTRL.converter0_enable == $past(PWDATA[2]))
      else $error("converter0 enable not updated");
   a_div_ctrl: assert property (
      s_wr(CLK_DIV_ADDR) |=> CTRL.clock_divider == $past(PWDATA[7:0]))
      else $error("clock divider not updated");
endmodule

bind regbank regbank_sva chk
(
   .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
   .BIT_MODE(BIT_MODE), .PREADY(PREADY), .PRDATA(PRDATA), .CTRL(CTRL)
);

// File: testbench.sv
// testbench: directed register bank checks over APB
`timescale 1ns/1ps
module testbench;
   import regbank_pkg::*;
   logic        CLK, RST_N, PSEL, PENABLE, PWRITE, BIT_MODE, PREADY, PSLVERR;
   logic        CONV_DONE_SET, COMPARATOR1_CONTROL_CHANGE_SET, COMPARATOR2_CONTROL_CHANGE_SET;
   logic        COMPARATOR1_CONTROL_OUT, COMPARATOR2_CONTROL_OUT, err;
   logic [31:0] PADDR, PWDATA, PRDATA, rd;
   logic [3:0]  PSTRB;
   logic [7:0]  t_addr [24];
   logic [7:0]  t_val [24];
   ctrl_t       CTRL;
   int          n_fail, num_checks;

   regbank dut
   (
      .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
      .BIT_MODE(BIT_MODE), .CONV_DONE_SET(CONV_DONE_SET),
      .COMPARATOR1_CONTROL_CHANGE_SET(COMPARATOR1_CONTROL_CHANGE_SET), .COMPARATOR2_CONTROL_CHANGE_SET(COMPARATOR2_CONTROL_CHANGE_SET),
      .COMPARATOR1_CONTROL_OUT(COMPARATOR1_CONTROL_OUT), .COMPARATOR2_CONTROL_OUT(COMPARATOR2_CONTROL_OUT), .PREADY(PREADY),
      .PRDATA(PRDATA), .PSLVERR(PSLVERR), .CTRL(CTRL)
   );

   // ----------------
   // helpers
   // ----------------
   // 100 ns clock
   always #50 CLK = ~CLK;

   task check(input string name, input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task summarize;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // one transfer; request held until ready is sampled high
   // waits with no limit of its own; only the watchdog ends a hang
   task apb(input logic wr, bm, input logic [7:0] a, d);
      logic early;
      @(posedge CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      BIT_MODE <= bm;
      PSTRB <= wr ? 4'hF : 4'h0;
      PADDR <= {22'h0, a, 2'h0};
      PWDATA <= {24'h0, d};
      @(posedge CLK);
      early = PREADY;
      PENABLE <= 1'b1;
      do
      begin
         @(posedge CLK);
      end
      while (PREADY !== 1'b1);
      check("pready early", {31'h0, early}, 32'h0);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   // ----------------
   // scenarios
   // ----------------
   task test_resets;
      for (int i = 0; i < 24; i++)
      begin
         apb(1'b0, 1'b0, t_addr[i], 8'h00);
         check("reset", rd, (t_addr[i] == BND_HI_ADDR) ? 32'hFF : 32'h0);
      end
      $display("test_resets done");
   endtask

   // defined bits only are written; reserved bits are left at zero
   task test_rw;
      for (int i = 0; i < 24; i++)
      begin
         apb(1'b1, 1'b0, t_addr[i], t_val[i]);
         apb(1'b0, 1'b0, t_addr[i], 8'h00);
         check("rw", rd, {24'h0, t_val[i]});
         apb(1'b1, 1'b0, t_addr[i], 8'h00);
         apb(1'b0, 1'b0, t_addr[i], 8'h00);
         check("clear", rd, 32'h0);
      end
      $display("test_rw done");
   endtask

   task test_bits;
      logic [7:0] base, a;
      for (int j = 0; j < 2; j++)
      begin
         base = j ? BREG_BIT_BASE : ACC_BIT_BASE;
         a = j ? BREG_ADDR : ACC_ADDR;
         for (int i = 0; i < 8; i++)
         begin
            apb(1'b1, 1'b1, base + 8'(i), 8'h01);
            apb(1'b0, 1'b0, a, 8'h00);
            check("bit set", rd, {24'h0, 8'hFF >> (7 - i)});
         end
         apb(1'b1, 1'b1, base + 8'h03, 8'h00);
         apb(1'b0, 1'b1, base + 8'h03, 8'h00);
         check("bit3", {31'h0, rd[0]}, 32'h0);
         apb(1'b0, 1'b1, base + 8'h04, 8'h00);
         check("bit4", {31'h0, rd[0]}, 32'h1);
         apb(1'b0, 1'b0, a, 8'h00);
         check("byte", rd, 32'hF7);
      end
      $display("test_bits done");
   endtask

   // a write lands at the access edge, so CTRL is looked at one edge later
   task test_ctrl;
      apb(1'b1, 1'b0, CONV1_CTL, 8'hE7);
      @(posedge CLK);
      check("conv1", {25'h0, CTRL.boundary_irq_enable,
         CTRL.conversion_irq_enable, CTRL.timer_trigger_mode,
         CTRL.edge_trigger_mode, CTRL.converter1_enable,
         CTRL.start_mode}, 32'h77);
      apb(1'b1, 1'b0, CONV1_CTL, 8'h10);
      @(posedge CLK);
      check("edge", {31'h0, CTRL.edge_trigger_mode}, 32'h1);
      apb(1'b1, 1'b0, BAUD_CTL_ADDR, 8'h02);
      @(posedge CLK);
      check("baud", {30'h0, CTRL.baud_source_select,
         CTRL.baud_generator_enable}, 32'h2);
      apb(1'b1, 1'b0, AUX_ADDR, 8'hC1);
      @(posedge CLK);
      check("aux", {27'h0, CTRL.clock_low_power, CTRL.break_reset_enable,
         CTRL.timer1_toggle_enable, CTRL.timer0_toggle_enable,
         CTRL.pointer_select}, 32'h19);
      // software reset is a one-cycle request that clears itself
      apb(1'b1, 1'b0, AUX_ADDR, 8'h08);
      @(posedge CLK);
      check("sreset on", {31'h0, CTRL.software_reset}, 32'h1);
      @(posedge CLK);
      check("sreset off", {31'h0, CTRL.software_reset}, 32'h0);
      apb(1'b1, 1'b0, COMPARATOR2_CONTROL_ADDR, 8'h24);
      @(posedge CLK);
      check("comparator2_control", {26'h0, CTRL.comparator2}, 32'h24);
      apb(1'b1, 1'b0, CONV0_CTL, 8'h04);
      @(posedge CLK);
      check("conv0", {31'h0, CTRL.converter0_enable}, 32'h1);
      apb(1'b1, 1'b0, CLK_DIV_ADDR, 8'h81);
      @(posedge CLK);
      check("divider", {24'h0, CTRL.clock_divider}, 32'h81);
      $display("test_ctrl done");
   endtask

   // done and comparator1 change inputs pulse once, comparator1 output stays high; then software clears the done flag
   task test_flags;
      @(posedge CLK);
      CONV_DONE_SET <= 1'b1;
      COMPARATOR1_CONTROL_CHANGE_SET <= 1'b1;
      COMPARATOR1_CONTROL_OUT <= 1'b1;
      @(posedge CLK);
      CONV_DONE_SET <= 1'b0;
      COMPARATOR1_CONTROL_CHANGE_SET <= 1'b0;
      apb(1'b0, 1'b0, CONV1_CTL, 8'h00);
      check("done flag", {31'h0, rd[3]}, 32'h1);
      apb(1'b0, 1'b0, COMPARATOR1_CONTROL_ADDR, 8'h00);
      check("comparator1_control status", {30'h0, rd[1:0]}, 32'h3);
      apb(1'b1, 1'b0, CONV1_CTL, 8'h00);
      apb(1'b0, 1'b0, CONV1_CTL, 8'h00);
      check("done clear", rd, 32'h0);
      apb(1'b0, 1'b0, 8'h80, 8'h00);
      check("unmapped", {31'h0, err}, 32'h1);
      COMPARATOR1_CONTROL_OUT <= 1'b0;
      $display("test_flags done");
   endtask

   // ----------------
   // main sequence and watchdog
   // ----------------
   initial
   begin
      t_addr = '{DPTR_LO_ADDR, DPTR_HI_ADDR, CONV0_CTL, CLK_DIV_ADDR,
         CONV1_CTL, MODE_B_ADDR, AUX_ADDR, INSEL_ADDR, COMPARATOR1_CONTROL_ADDR, COMPARATOR2_CONTROL_ADDR,
         BND_LO_ADDR, BAUD_CTL_ADDR, BAUD_LO_ADDR, BAUD_HI_ADDR,
         MODE_A_ADDR, BND_HI_ADDR, RES0_ADDR, RES1_ADDR, RES2_ADDR,
         ACC_ADDR, FLASH_HI_ADDR, BREG_ADDR, C0RES3_ADDR, C1RES3_ADDR};
      t_val = '{8'hA5, 8'h5A, CONV0_MASK, 8'hA5, 8'hF7, MODE_B_MASK,
         8'hF1, INSEL_MASK, 8'h3C, 8'h3C, 8'hA5, BAUD_CTL_MASK, 8'h5A,
         8'hA5, 8'h70, 8'h5A, 8'hA5, 8'h5A, 8'hA5, 8'h5A, 8'hA5, 8'h5A,
         8'hA5, 8'h5A};
      {CLK, RST_N, PSEL, PENABLE, PWRITE, BIT_MODE} = 6'h0;
      {CONV_DONE_SET, COMPARATOR1_CONTROL_CHANGE_SET, COMPARATOR2_CONTROL_CHANGE_SET} = 3'h0;
      {COMPARATOR1_CONTROL_OUT, COMPARATOR2_CONTROL_OUT} = 2'h0;
      {PADDR, PWDATA, PSTRB} = 68'h0;
      repeat (8) @(posedge CLK);
      RST_N <= 1'b1;
      test_resets();
      test_rw();
      test_bits();
      test_ctrl();
      test_flags();
      // second reset in mid-run must restore every reset value
      RST_N <= 1'b0;
      repeat (3) @(posedge CLK);
      RST_N <= 1'b1;
      test_resets();
      summarize();
   end

   // the tests need about 620 cycles; over thirty times that means a hang
   initial
   begin
      repeat (20000) @(posedge CLK);
      n_fail++;
      $display("watchdog expired");
      summarize();
   end
endmodule
